// *** src/clsr_consts.vh ***
`ifndef CLSR_CONSTS_VH
`define CLSR_CONSTS_VH
// register subaddresses
`define CLSR_A_BLUE_FINE_HI 8'h0b
`define CLSR_A_GREEN_FINE_HI 8'h0c
`define CLSR_A_RED_FINE_HI 8'h0d
`define CLSR_A_RED_GAIN 8'h1c
`define CLSR_A_FINE_LO 8'h1d
`define CLSR_A_BLUE_COARSE 8'h1e
`define CLSR_A_GREEN_COARSE 8'h1f
`define CLSR_A_RED_COARSE 8'h20
`define CLSR_A_HS_START 8'h21
`define CLSR_A_MISC 8'h22
`define CLSR_A_BLUE_LVL_LO 8'h23
`define CLSR_A_GREEN_LVL_LO 8'h24
`define CLSR_A_RED_LVL_LO 8'h25
`define CLSR_A_LVL_EN 8'h26
`define CLSR_A_LVL_HI 8'h27
// reset values
`define CLSR_RST_FINE_HI 8'h80
`define CLSR_RST_RED_GAIN 4'h7
`define CLSR_RST_FINE_LO 6'h00
`define CLSR_RST_COARSE 6'h10
`define CLSR_RST_HS_START 8'h0d
`define CLSR_RST_MISC 8'h08
`define CLSR_RST_LVL_EN 1'b1
// misc control field positions
`define CLSR_MISC_SYNC_PROC_RESET 7
`define CLSR_MISC_LUMA_HI 6
`define CLSR_MISC_LUMA_LO 4
`define CLSR_MISC_STRIP 3
`define CLSR_MISC_COAST_DIS 2
`define CLSR_MISC_VS_SEL 1
`define CLSR_MISC_VSYNC_TIMING_BYPASS 0
// level enable bit, level filter figures
`define CLSR_LVL_EN_BIT 7
`define CLSR_LVL_MAX_SHIFT 4'd10
`define CLSR_LVL_FRAC 10
`endif

// *** src/clsr_level_filter.v ***
`timescale 1ns/100ps
`include "clsr_consts.vh"
// one channel of the level-control loop: first-order recursive filter
module clsr_level_filter (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire enable,
  input wire hold_rst,
  input wire line_tick,
  input wire [3:0] coef,
  // data
  input wire [9:0] adc_sample,
  output reg [9:0] level_r
);
  reg signed [19:0] acc_r; // result with ten fraction bits
  wire signed [9:0] centred; // sample minus 512
  wire signed [20:0] diff;
  wire signed [20:0] step;
  wire [3:0] shift;
  wire signed [19:0] acc_nxt;

  // flipping the top bit subtracts 512 and yields two's complement
  assign centred = {~adc_sample[9], adc_sample[8:0]};
  assign diff = {centred[9], centred, 10'h000} - {acc_r[19], acc_r};
  // codes above ten all act as the slowest coefficient
  assign shift = (coef > `CLSR_LVL_MAX_SHIFT) ? `CLSR_LVL_MAX_SHIFT : coef;
  assign step = diff >>> shift;
  assign acc_nxt = acc_r + step[19:0];

  // update once per line while enabled
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_r <= 20'sh00000;
      level_r <= 10'h000;
    end else if (hold_rst) begin
      acc_r <= 20'sh00000;
      level_r <= 10'h000;
    end else if (enable && line_tick) begin
      acc_r <= acc_nxt;
      level_r <= acc_nxt[19:`CLSR_LVL_FRAC];
    end
  end
endmodule // clsr_level_filter

// *** src/clsr_regs.v ***
`timescale 1ns/100ps
`include "clsr_consts.vh"
module clsr_regs (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // subaddress port from the serial interface engine
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  // analog front-end settings
  output reg [3:0] red_gain_r,
  output reg [5:0] blue_coarse_r,
  output reg [5:0] green_coarse_r,
  output reg [5:0] red_coarse_r,
  output reg [9:0] blue_fine_r,
  output reg [9:0] green_fine_r,
  output reg [9:0] red_fine_r,
  // sync processing
  input wire hsync_in,
  input wire sep_vsync,
  input wire accum_vsync,
  input wire [7:0] vsync_align,
  input wire ext_coast_sel,
  input wire ext_coast,
  input wire int_coast,
  output reg hsync_output_r,
  output reg vsync_output_r,
  output reg coast_r,
  output reg sync_proc_reset_r,
  output reg copy_strip_enable_r,
  // luma and chroma path
  input wire [9:0] luma_in,
  input wire [9:0] chroma_in,
  output reg [9:0] luma_out_r,
  output reg [9:0] chroma_out_r,
  // level control
  input wire line_tick,
  input wire [3:0] level_vertical_coef,
  input wire [29:0] adc_data,
  output reg auto_level_control_r
);
  // writable register fields
  reg [7:0] fine_hi_r [0:2]; // blue, green, red msbs
  reg [5:0] fine_lo_r; // red 5:4, green 3:2, blue 1:0
  reg [7:0] hs_start_r;
  reg [7:0] misc_r;
  reg lvl_en_r;
  // level results per channel, blue at index 0
  wire [9:0] level [0:2];
  // hsync pin synchroniser
  reg hs_meta_r;
  reg hs_sync_r;
  // luma delay line
  reg [9:0] luma_pipe_r [0:7];
  // delay units: index 0 hsync, index 1 vsync
  wire [1:0] dly_src;
  wire [7:0] dly_start [0:1];
  reg [1:0] dly_prev_r;
  reg [1:0] dly_busy_r;
  reg [1:0] dly_out_r;
  reg [7:0] dly_cnt_r [0:1];
  wire sp_rst;
  wire vs_src;
  wire [2:0] luma_dly;
  integer k;

  // read decode for the registered read path
  function [7:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `CLSR_A_BLUE_FINE_HI: rd_mux = fine_hi_r[0];
        `CLSR_A_GREEN_FINE_HI: rd_mux = fine_hi_r[1];
        `CLSR_A_RED_FINE_HI: rd_mux = fine_hi_r[2];
        `CLSR_A_RED_GAIN: rd_mux = {4'h0, red_gain_r};
        `CLSR_A_FINE_LO: rd_mux = {2'h0, fine_lo_r};
        `CLSR_A_BLUE_COARSE: rd_mux = {2'h0, blue_coarse_r};
        `CLSR_A_GREEN_COARSE: rd_mux = {2'h0, green_coarse_r};
        `CLSR_A_RED_COARSE: rd_mux = {2'h0, red_coarse_r};
        `CLSR_A_HS_START: rd_mux = hs_start_r;
        `CLSR_A_MISC: rd_mux = misc_r;
        `CLSR_A_BLUE_LVL_LO: rd_mux = level[0][7:0];
        `CLSR_A_GREEN_LVL_LO: rd_mux = level[1][7:0];
        `CLSR_A_RED_LVL_LO: rd_mux = level[2][7:0];
        `CLSR_A_LVL_EN: rd_mux = {lvl_en_r, 7'h00};
        `CLSR_A_LVL_HI: rd_mux = {2'h0, level[2][9:8], level[1][9:8], level[0][9:8]};
        default: rd_mux = 8'h00; // unmapped reads as zero
      endcase
    end
  endfunction

  assign sp_rst = misc_r[`CLSR_MISC_SYNC_PROC_RESET];
  assign luma_dly = misc_r[`CLSR_MISC_LUMA_HI:`CLSR_MISC_LUMA_LO];

  // register writes; reserved bits are dropped
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fine_hi_r[0] <= `CLSR_RST_FINE_HI;
      fine_hi_r[1] <= `CLSR_RST_FINE_HI;
      fine_hi_r[2] <= `CLSR_RST_FINE_HI;
      red_gain_r <= `CLSR_RST_RED_GAIN;
      fine_lo_r <= `CLSR_RST_FINE_LO;
      blue_coarse_r <= `CLSR_RST_COARSE;
      green_coarse_r <= `CLSR_RST_COARSE;
      red_coarse_r <= `CLSR_RST_COARSE;
      hs_start_r <= `CLSR_RST_HS_START;
      misc_r <= `CLSR_RST_MISC;
      lvl_en_r <= `CLSR_RST_LVL_EN;
    end else if (reg_wr) begin
      case (reg_addr)
        `CLSR_A_BLUE_FINE_HI: fine_hi_r[0] <= reg_wdata;
        `CLSR_A_GREEN_FINE_HI: fine_hi_r[1] <= reg_wdata;
        `CLSR_A_RED_FINE_HI: fine_hi_r[2] <= reg_wdata;
        `CLSR_A_RED_GAIN: red_gain_r <= reg_wdata[3:0]; // code only, analog side maps the gain
        `CLSR_A_FINE_LO: fine_lo_r <= reg_wdata[5:0];
        `CLSR_A_BLUE_COARSE: blue_coarse_r <= reg_wdata[5:0];
        `CLSR_A_GREEN_COARSE: green_coarse_r <= reg_wdata[5:0];
        `CLSR_A_RED_COARSE: red_coarse_r <= reg_wdata[5:0];
        `CLSR_A_HS_START: hs_start_r <= reg_wdata;
        `CLSR_A_MISC: misc_r <= reg_wdata;
        `CLSR_A_LVL_EN: lvl_en_r <= reg_wdata[`CLSR_LVL_EN_BIT];
        default: ; // read-only and unmapped writes ignored
      endcase
    end
  end

  // read data registered; holds until the next read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux(reg_addr);
    end
  end

  // settings to the front end; codes pass through unchanged,
  // the analog side decodes gain and sign-magnitude offsets
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blue_fine_r <= 10'h000;
      green_fine_r <= 10'h000;
      red_fine_r <= 10'h000;
      sync_proc_reset_r <= 1'b0;
      copy_strip_enable_r <= 1'b0;
      auto_level_control_r <= 1'b0;
      coast_r <= 1'b0;
    end else begin
      blue_fine_r <= {fine_hi_r[0], fine_lo_r[1:0]};
      green_fine_r <= {fine_hi_r[1], fine_lo_r[3:2]};
      red_fine_r <= {fine_hi_r[2], fine_lo_r[5:4]};
      sync_proc_reset_r <= sp_rst;
      copy_strip_enable_r <= misc_r[`CLSR_MISC_STRIP];
      auto_level_control_r <= lvl_en_r;
      // disable bit only gates the internal coast source
      coast_r <= ext_coast_sel ? ext_coast : (int_coast & ~misc_r[`CLSR_MISC_COAST_DIS]);
    end
  end

  // two-flop synchroniser for the hsync pin
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hs_meta_r <= 1'b0;
      hs_sync_r <= 1'b0;
    end else begin
      hs_meta_r <= hsync_in;
      hs_sync_r <= hs_meta_r;
    end
  end

  // vsync source choice
  assign vs_src = misc_r[`CLSR_MISC_VS_SEL] ? accum_vsync : sep_vsync;
  assign dly_src = {vs_src, hs_sync_r};
  assign dly_start[0] = hs_start_r;
  assign dly_start[1] = vsync_align;

  // leading-edge delay units, held idle during sync reset
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : dly
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          dly_prev_r[g] <= 1'b0;
          dly_busy_r[g] <= 1'b0;
          dly_out_r[g] <= 1'b0;
          dly_cnt_r[g] <= 8'h00;
        end else if (sp_rst) begin
          dly_prev_r[g] <= 1'b0;
          dly_busy_r[g] <= 1'b0;
          dly_out_r[g] <= 1'b0;
          dly_cnt_r[g] <= 8'h00;
        end else begin
          dly_prev_r[g] <= dly_src[g];
          if (dly_src[g] && !dly_prev_r[g]) begin
            // leading edge: start counting, or fire at once for zero
            dly_cnt_r[g] <= 8'h01;
            dly_busy_r[g] <= (dly_start[g] != 8'h00);
            dly_out_r[g] <= (dly_start[g] == 8'h00);
          end else if (dly_busy_r[g]) begin
            if (dly_cnt_r[g] == dly_start[g]) begin
              dly_out_r[g] <= 1'b1;
              dly_busy_r[g] <= 1'b0;
            end else begin
              dly_cnt_r[g] <= dly_cnt_r[g] + 8'h01;
            end
          end else if (!dly_src[g]) begin
            // trailing edge follows the source once placed
            dly_out_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // sync outputs; bypass takes the separator straight through
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hsync_output_r <= 1'b0;
      vsync_output_r <= 1'b0;
    end else begin
      hsync_output_r <= dly_out_r[0];
      if (misc_r[`CLSR_MISC_VSYNC_TIMING_BYPASS]) begin
        vsync_output_r <= sp_rst ? 1'b0 : sep_vsync;
      end else begin
        vsync_output_r <= dly_out_r[1];
      end
    end
  end

  // luma delay line; chroma only registered
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (k = 0; k < 8; k = k + 1) begin
        luma_pipe_r[k] <= 10'h000;
      end
      luma_out_r <= 10'h000;
      chroma_out_r <= 10'h000;
    end else begin
      luma_pipe_r[0] <= luma_in;
      for (k = 1; k < 8; k = k + 1) begin
        luma_pipe_r[k] <= luma_pipe_r[k - 1];
      end
      // zero picks the undelayed sample
      luma_out_r <= (luma_dly == 3'h0) ? luma_in : luma_pipe_r[luma_dly - 3'h1];
      chroma_out_r <= chroma_in;
    end
  end

  // one level filter per channel: blue, green, red
  generate
    for (g = 0; g < 3; g = g + 1) begin : lvl
      clsr_level_filter u_filt (
        .core_clk(core_clk),
        .rst(rst),
        .enable(lvl_en_r),
        .hold_rst(sp_rst),
        .line_tick(line_tick),
        .coef(level_vertical_coef),
        .adc_sample(adc_data[g * 10 + 9:g * 10]),
        .level_r(level[g])
      );
    end
  endgenerate
endmodule // clsr_regs

// *** tb/clsr_host.sv ***
`timescale 1ns/100ps
// host on the subaddress port: one strobe cycle per access, idle cycle after
module clsr_host (
  // clock
  input wire core_clk,
  // subaddress port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // write; address and data scrambled once released
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // read; data is taken one edge after the strobe is taken
  task rd(input [7:0] a, output [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    v = reg_rdata_r;
  endtask
  // level result: high bits then low byte back to back, filter may move between
  task lvl(input int s, output [9:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(8'h27, h);
    rd(8'h23 + 8'(s), l);
    v = {h[2*s+:2], l};
  endtask
endmodule // clsr_host

// *** tb/clsr_regs_sva.sv ***
`timescale 1ns/100ps
// port-level checks of the register port and the hsync output
module clsr_regs_sva (
  input wire core_clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r,
  input wire [3:0] red_gain_r,
  input wire [5:0] blue_coarse_r,
  input wire [9:0] red_fine_r,
  input wire hsync_output_r,
  input wire sync_proc_reset_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  gain_write_a: assert property (reg_wr && reg_addr == 8'h1c |=> red_gain_r == $past(reg_wdata[3:0]))
    else $error("gain write lost");
  coarse_write_a: assert property (reg_wr && reg_addr == 8'h1e |=> blue_coarse_r == $past(reg_wdata[5:0]))
    else $error("coarse write lost");
  fine_msb_a: assert property (reg_wr && reg_addr == 8'h0d |=> ##1 red_fine_r[9:2] == $past(reg_wdata, 2))
    else $error("fine high bits lost");
  gain_resv_a: assert property (reg_rd && reg_addr == 8'h1c |=> reg_rdata_r[7:4] == 4'h0)
    else $error("gain spare bits set");
  fine_resv_a: assert property (reg_rd && reg_addr == 8'h1d |=> reg_rdata_r[7:6] == 2'h0)
    else $error("fine low spare bits set");
  lvl_en_read_a: assert property (reg_rd && reg_addr == 8'h26 |=> reg_rdata_r[6:0] == 7'h00)
    else $error("enable spare bits set");
  msb_resv_a: assert property (reg_rd && reg_addr == 8'h27 |=> reg_rdata_r[7:6] == 2'h0)
    else $error("result high spare bits set");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_r))
    else $error("read data moved");
  sync_hold_a: assert property (sync_proc_reset_r && $past(sync_proc_reset_r, 2) |-> !hsync_output_r)
    else $error("hsync out under sync reset");
endmodule // clsr_regs_sva

bind clsr_regs clsr_regs_sva chk_u (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .red_gain_r(red_gain_r),
  .blue_coarse_r(blue_coarse_r), .red_fine_r(red_fine_r), .hsync_output_r(hsync_output_r),
  .sync_proc_reset_r(sync_proc_reset_r));

// *** tb/tb_clsr_regs.sv ***
`timescale 1ns/100ps
// register bank bench: host task calls with expected values
module tb_clsr_regs;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, hsync_in = 1'b0, sep_vsync = 1'b0, accum_vsync = 1'b0;
  logic ext_coast_sel = 1'b0, ext_coast = 1'b0, int_coast = 1'b1, line_tick = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, vsync_align = 8'h00, v;
  logic [9:0] luma_in = 10'h000, chroma_in = 10'h000, red_fine_r, green_fine_r, blue_fine_r, luma_out_r, chroma_out_r, r;
  logic [3:0] red_gain_r, level_vertical_coef = 4'h0;
  logic [5:0] blue_coarse_r, green_coarse_r, red_coarse_r;
  logic [29:0] adc_data = {10'h3ff, 10'h200, 10'h000};
  logic hsync_output_r, vsync_output_r, coast_r, sync_proc_reset_r, copy_strip_enable_r, auto_level_control_r;
  int n_errors = 0, checked = 0, n, i;
  // reset-value table: {address, expected read}; 40h is unmapped
  logic [15:0] rtab [12] = '{16'h1c07, 16'h1d00, 16'h1e10, 16'h1f10, 16'h2010, 16'h210d,
    16'h2208, 16'h2680, 16'h0d80, 16'h0c80, 16'h0b80, 16'h4000};
  logic [9:0] lx [3] = '{10'h200, 10'h000, 10'h1ff};
  // offset searches: blank base, stop limit, expected code and result
  int bs [2] = '{100, 600}, lim [2] = '{-496, 0};
  logic [5:0] c, cx [2] = '{6'h35, 6'h36};
  logic [9:0] rx [2] = '{10'h210, 10'h000};
  clsr_regs dut_u (.*);
  clsr_host host_u (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));
  always #2 core_clk = ~core_clk;
  task chk(input string w, input [9:0] e, input [9:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task report_and_stop;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one line of the level filter
  task tick;
    @(posedge core_clk) line_tick <= 1'b1;
    @(posedge core_clk) line_tick <= 1'b0;
  endtask
  // cut a hang short; whole run is well under this
  initial begin
    #40000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    for (i = 0; i < 12; i++) begin
      host_u.rd(rtab[i][15:8], v);
      chk("reset read", rtab[i][7:0], v);
    end
    chk("gain", 10'h7, red_gain_r);
    chk("coarse", 10'h10, green_coarse_r);
    chk("fine", 10'h200, blue_fine_r);
    chk("green fine", 10'h200, green_fine_r);
    chk("strip", 10'h1, copy_strip_enable_r);
    chk("level on", 10'h1, auto_level_control_r);
    chk("coast on", 10'h1, coast_r);
    // field writes, spare bits dropped, read-only ignored
    host_u.wr(8'h1c, 8'hff);
    host_u.wr(8'h1d, 8'hff);
    host_u.wr(8'h0d, 8'ha5);
    host_u.wr(8'h1e, 8'h21);
    host_u.wr(8'h23, 8'hff);
    host_u.rd(8'h1c, v);
    chk("gain read", 10'h0f, v);
    host_u.rd(8'h1d, v);
    chk("fine low read", 10'h3f, v);
    chk("red fine", 10'h297, red_fine_r);
    chk("blue coarse", 10'h21, blue_coarse_r);
    host_u.rd(8'h23, v);
    chk("result read-only", 10'h00, v);
    // coefficient 0: one line settles fully on adc minus 512
    tick;
    for (i = 0; i < 3; i++) begin
      host_u.lvl(i, r);
      chk("level result", lx[i], r);
    end
    host_u.wr(8'h26, 8'h00);
    adc_data <= 30'h0;
    tick;
    host_u.lvl(2, r);
    chk("frozen result", 10'h1ff, r);
    host_u.rd(8'h26, v);
    chk("level off", 10'h00, {v[7:1], auto_level_control_r});
    host_u.wr(8'h26, 8'h80);
    // offset searches on red; stand-in front end: blank at base plus 4 counts per code step
    for (i = 0; i < 2; i++) begin
      c = 6'h10;
      r = 10'h1ff;
      for (n = 0; $signed(r) > lim[i] && n < 64; n++) begin
        // sign-magnitude decrement: 01h goes to 00h, then on to 21h for -1
        if (n > 0) c = c[5] ? c + 6'h01 : (c == 6'h00 ? 6'h21 : c - 6'h01);
        host_u.wr(8'h20, {2'h0, c});
        adc_data[29:20] <= 10'(bs[i] + (c[5] ? -4 : 4) * int'(c[4:0]));
        tick;
        host_u.lvl(2, r);
      end
      chk("clamp code", {4'h0, cx[i]}, {4'h0, red_coarse_r});
      chk("clamp result", rx[i], r);
    end
    // luma delay: field 3 gives four cycles
    host_u.wr(8'h22, 8'h38);
    @(posedge core_clk) luma_in <= 10'h155;
    chroma_in <= 10'h155;
    for (n = 0; luma_out_r !== 10'h155 && n < 20; n++) @(negedge core_clk);
    chk("luma delay", 10'd5, 10'(n));
    chk("chroma", 10'h155, chroma_out_r);
    // hsync out start: loop count is pin sync, edge detect, start, output flop, plus one
    for (i = 0; i < 8; i += 7) begin
      host_u.wr(8'h21, 8'(i));
      @(posedge core_clk) hsync_in <= 1'b1;
      for (n = 0; hsync_output_r !== 1'b1 && n < 40; n++) @(negedge core_clk);
      chk("hsync delay", 10'(i + 5), 10'(n));
      @(posedge core_clk) hsync_in <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
    // sync processing held in reset
    host_u.wr(8'h22, 8'h88);
    @(posedge core_clk) hsync_in <= 1'b1;
    repeat (12) @(negedge core_clk);
    chk("held hsync", 10'h0, {sync_proc_reset_r, hsync_output_r} ^ 2'b10);
    @(posedge core_clk) hsync_in <= 1'b0;
    // coast: internal gated by disable bit, external overrides
    host_u.wr(8'h22, 8'h0c);
    repeat (2) @(negedge core_clk);
    chk("coast off", 10'h0, coast_r);
    @(posedge core_clk) ext_coast_sel <= 1'b1;
    ext_coast <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("ext coast", 10'h1, coast_r);
    // vsync source select, then bypass follows separator
    @(posedge core_clk) accum_vsync <= 1'b1;
    host_u.wr(8'h22, 8'h0a);
    repeat (8) @(negedge core_clk);
    chk("vsync accum", 10'h1, vsync_output_r);
    host_u.wr(8'h22, 8'h08);
    repeat (8) @(negedge core_clk);
    chk("vsync sep", 10'h0, vsync_output_r);
    host_u.wr(8'h22, 8'h09);
    // a long alignment count would hold the edge back if bypass were not taken
    sep_vsync <= 1'b1;
    vsync_align <= 8'h20;
    repeat (2) @(negedge core_clk);
    chk("vsync bypass", 10'h1, vsync_output_r);
    report_and_stop;
  end
endmodule // tb_clsr_regs
